// *** logic/mrx_pkg.sv ***
// shared constants and types for the receive status port
package mrx_pkg;
   // core clock and strap settle timing
   localparam int CORE_PERIOD_NS  = 100;
   localparam int STRAP_SETTLE_NS = 300;
   localparam int STRAP_WAIT_CYC  =
      (STRAP_SETTLE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
   localparam int STRAP_CNT_W     = 4;

   // widths of the receive data path
   localparam int RXD_W      = 4;
   localparam int RMII_RXD_W = 2;
   localparam int ADDR_W     = 5;

   // bit positions inside the shared pin bundle
   localparam int PIN_W       = 8;
   localparam int PIN_RXD_LSB = 0;
   localparam int PIN_DV      = 4;
   localparam int PIN_ER      = 5;
   localparam int PIN_CRS     = 6;
   localparam int PIN_COL     = 7;

   // pull defaults on the shared pins: rxd/dv low, er/crs/col high
   localparam logic [PIN_W-1:0]  STRAP_RST     = 8'hE0;
   localparam logic [ADDR_W-1:0] MGMT_ADDR_RST = 5'h01;

   // nibble delivered in place of data on a receive error
   localparam logic [RXD_W-1:0]  CORRUPT_NIBBLE = 4'hE;

   // config word crossing into the link domain
   localparam int CFG_W    = 2;
   localparam int CFG_RMII = 0;
   localparam int CFG_FDX  = 1;

   // strap capture sequence
   typedef enum logic [2:0] {
      ST_SETTLE = 3'b001,
      ST_LATCH  = 3'b010,
      ST_DRIVE  = 3'b100
   } mrx_strap_st_t;
endpackage : mrx_pkg

// *** logic/mrx_sync.sv ***
// two flip-flop level synchroniser, any width
`timescale 1ns/1ps
module mrx_sync #(
   parameter int         W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   // first stage feeds only the second stage
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_ff <= RST;
         sync_ff <= RST;
      end else begin
         meta_ff <= i_d;
         sync_ff <= meta_ff;
      end
   end

   assign o_q = sync_ff;
endmodule : mrx_sync

// *** logic/mrx_rx_port.sv ***
// receive side pins toward the mac, with straps and pair control
// Notes on behaviour
// - rx data valid high while valid data sits on the data lines
// - rx error high on an error symbol, on the receive-side clock
// - data is corrupted on error, so the mac may ignore rx error
// - decoded nibble in mii, two bits in rmii, valid only with dv
// - address bits 4..1 from rxd straps, bit 0 from collision strap
// - with no strap resistors the address comes out as one
// - mii carrier sense high whenever the receive medium is busy
// - rmii carrier sense pin carries combined carrier and data valid
// - mii full duplex holds collision low always
// - half duplex collision high only when tx and rx both busy
// - collision unused in rmii; the mac must not rely on it
// - line pairs follow 10base-t or 100base-tx by speed
// - with crossover in effect the pairs swap roles
// - mii receive clock is 25 mhz at 100 or 2.5 mhz at 10
`timescale 1ns/1ps
module mrx_rx_port
   import mrx_pkg::*;
#(
   parameter int SETTLE_CYC = STRAP_WAIT_CYC
) (
   input  wire logic             I_CORE_CLK,
   input  wire logic             I_RST,
   input  wire logic             I_LINK_CLK,
   input  wire logic [RXD_W-1:0] I_RXD_PIN,
   input  wire logic             I_RX_DV_PIN,
   input  wire logic             I_RX_ER_PIN,
   input  wire logic             I_CRS_PIN,
   input  wire logic             I_COL_PIN,
   input  wire logic             I_FULL_DUPLEX,
   input  wire logic             I_SPEED_100,
   input  wire logic             I_SWAP_REQ,
   input  wire logic             I_SYM_VALID,
   input  wire logic [RXD_W-1:0] I_SYM_DATA,
   input  wire logic             I_SYM_ERR,
   input  wire logic             I_RX_ACTIVE,
   input  wire logic             I_TX_ACTIVE,
   output logic      [RXD_W-1:0] O_RXD,
   output logic                  O_RX_DV,
   output logic                  O_RX_ER,
   output logic                  O_CRS,
   output logic                  O_COL,
   output logic                  O_PINS_OE,
   output logic     [ADDR_W-1:0] O_MGMT_ADDR,
   output logic                  O_RMII_MODE,
   output logic                  O_CROSSOVER_EN,
   output logic                  O_INDICATOR_CFG,
   output logic                  O_STRAPS_DONE,
   output logic                  O_LINE_100,
   output logic                  O_PAIRS_SWAPPED,
   output logic                  O_RXCLK_25M
);
   // ---------------- core clock domain ----------------
   logic [PIN_W-1:0]       pins_raw;
   logic [PIN_W-1:0]       pins_s;
   mrx_strap_st_t          st_ff;
   mrx_strap_st_t          nxt_st;
   logic [STRAP_CNT_W-1:0] wait_ff;
   logic [ADDR_W-1:0]      mgmt_addr_ff;
   logic                   rmii_ff;
   logic                   xover_en_ff;
   logic                   ind_cfg_ff;
   logic                   done_ff;
   logic                   oe_ff;
   logic                   line100_ff;
   logic                   swapped_ff;
   logic                   rxclk25_ff;
   logic [CFG_W-1:0]       cfg_core;

   // shared pins gathered into one bundle
   assign pins_raw = {I_COL_PIN, I_CRS_PIN, I_RX_ER_PIN, I_RX_DV_PIN,
                      I_RXD_PIN};

   // pins come from outside, so two flops before use
   mrx_sync #(
      .W   (PIN_W),
      .RST (STRAP_RST)
   ) u_pin_sync (
      .i_clk (I_CORE_CLK),
      .i_rst (I_RST),
      .i_d   (pins_raw),
      .o_q   (pins_s)
   );

   // strap sequence: settle, latch once, then drive
   always_comb begin
      nxt_st = st_ff;
      unique case (st_ff)
         ST_SETTLE: begin
            if (wait_ff >= STRAP_CNT_W'(SETTLE_CYC)) begin
               nxt_st = ST_LATCH;
            end
         end
         ST_LATCH: begin
            nxt_st = ST_DRIVE;
         end
         ST_DRIVE: begin
            nxt_st = ST_DRIVE;
         end
         default: begin
            nxt_st = ST_SETTLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         st_ff <= ST_SETTLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // settle counter after reset release
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         wait_ff <= '0;
      end else if (st_ff == ST_SETTLE) begin
         wait_ff <= wait_ff + STRAP_CNT_W'(1);
      end
   end

   // strap capture after release, pins still undriven
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         mgmt_addr_ff <= MGMT_ADDR_RST;
         rmii_ff      <= STRAP_RST[PIN_DV];
         xover_en_ff  <= STRAP_RST[PIN_ER];
         ind_cfg_ff   <= STRAP_RST[PIN_CRS];
         done_ff      <= 1'b0;
      end else if (st_ff == ST_LATCH) begin
         mgmt_addr_ff <= {pins_s[PIN_RXD_LSB +: RXD_W],
                          pins_s[PIN_COL]};
         rmii_ff      <= pins_s[PIN_DV];
         xover_en_ff  <= pins_s[PIN_ER];
         ind_cfg_ff   <= pins_s[PIN_CRS];
         done_ff      <= 1'b1;
      end
   end

   // output enable only once the straps are held
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         oe_ff <= 1'b0;
      end else begin
         oe_ff <= (st_ff == ST_DRIVE);
      end
   end

   // line pair mode, crossover and receive clock rate
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         line100_ff <= 1'b0;
         swapped_ff <= 1'b0;
         rxclk25_ff <= 1'b0;
      end else begin
         line100_ff <= I_SPEED_100;
         swapped_ff <= xover_en_ff & I_SWAP_REQ;
         // rmii runs on the 50 mhz reference instead
         rxclk25_ff <= ~rmii_ff & I_SPEED_100;
      end
   end

   assign cfg_core = {I_FULL_DUPLEX, rmii_ff};

   // core outputs
   assign O_PINS_OE       = oe_ff;
   assign O_MGMT_ADDR     = mgmt_addr_ff;
   assign O_RMII_MODE     = rmii_ff;
   assign O_CROSSOVER_EN  = xover_en_ff;
   assign O_INDICATOR_CFG = ind_cfg_ff;
   assign O_STRAPS_DONE   = done_ff;
   assign O_LINE_100      = line100_ff;
   assign O_PAIRS_SWAPPED = swapped_ff;
   assign O_RXCLK_25M     = rxclk25_ff;

   // ---------------- link clock domain ----------------
   logic [CFG_W-1:0] cfg_s;
   logic             rmii_s;
   logic             fdx_s;
   logic [RXD_W-1:0] rxd_ff;
   logic [RXD_W-1:0] nxt_rxd;
   logic             dv_ff;
   logic             er_ff;
   logic             crs_ff;
   logic             col_ff;
   logic             nxt_crs;
   logic             nxt_col;

   // mode levels cross into the link domain
   mrx_sync #(
      .W   (CFG_W),
      .RST ('0)
   ) u_cfg_sync (
      .i_clk (I_LINK_CLK),
      .i_rst (I_RST),
      .i_d   (cfg_core),
      .o_q   (cfg_s)
   );

   assign rmii_s = cfg_s[CFG_RMII];
   assign fdx_s  = cfg_s[CFG_FDX];

   // data path: corrupt on error, narrow in rmii, zero when idle
   always_comb begin
      nxt_rxd = '0;
      if (I_SYM_VALID && I_SYM_ERR) begin
         nxt_rxd = CORRUPT_NIBBLE;
      end else if (I_SYM_VALID) begin
         nxt_rxd = I_SYM_DATA;
      end
      if (rmii_s) begin
         nxt_rxd[RXD_W-1:RMII_RXD_W] = '0;
      end
   end

   // carrier sense and collision by mode
   always_comb begin
      nxt_crs = I_RX_ACTIVE;
      if (rmii_s) begin
         nxt_crs = I_RX_ACTIVE | I_SYM_VALID;
      end
      nxt_col = 1'b0;
      if (!rmii_s && !fdx_s) begin
         nxt_col = I_TX_ACTIVE & I_RX_ACTIVE;
      end
   end

   // registered receive outputs
   always_ff @(posedge I_LINK_CLK or posedge I_RST) begin
      if (I_RST) begin
         rxd_ff <= '0;
         dv_ff  <= 1'b0;
         er_ff  <= 1'b0;
      end else begin
         rxd_ff <= nxt_rxd;
         dv_ff  <= I_SYM_VALID;
         er_ff  <= I_SYM_VALID & I_SYM_ERR;
      end
   end

   // registered carrier and collision
   always_ff @(posedge I_LINK_CLK or posedge I_RST) begin
      if (I_RST) begin
         crs_ff <= 1'b0;
         col_ff <= 1'b0;
      end else begin
         crs_ff <= nxt_crs;
         col_ff <= nxt_col;
      end
   end

   assign O_RXD   = rxd_ff;
   assign O_RX_DV = dv_ff;
   assign O_RX_ER = er_ff;
   assign O_CRS   = crs_ff;
   assign O_COL   = col_ff;

   // ---------------- checks ----------------
   dv_follow_a: assert property (
      @(posedge I_LINK_CLK) disable iff (I_RST)
      I_SYM_VALID |=> O_RX_DV)
      else $error("valid data without rx data valid");

   err_flag_a: assert property (
      @(posedge I_LINK_CLK) disable iff (I_RST)
      (I_SYM_VALID && I_SYM_ERR) |=> (O_RX_ER && O_RX_DV))
      else $error("error symbol not flagged");

   data_corrupt_a: assert property (
      @(posedge I_LINK_CLK) disable iff (I_RST)
      (I_SYM_VALID && I_SYM_ERR && !rmii_s) |=>
         (O_RXD == CORRUPT_NIBBLE))
      else $error("errored data not corrupted");

   data_pass_a: assert property (
      @(posedge I_LINK_CLK) disable iff (I_RST)
      (I_SYM_VALID && !I_SYM_ERR && !rmii_s) |=>
         (O_RXD == $past(I_SYM_DATA)))
      else $error("mii nibble not delivered");

   rmii_narrow_a: assert property (
      @(posedge I_LINK_CLK) disable iff (I_RST)
      rmii_s |=> (O_RXD[RXD_W-1:RMII_RXD_W] == '0))
      else $error("rmii upper data bits not zero");

   addr_capture_a: assert property (
      @(posedge I_CORE_CLK) disable iff (I_RST)
      $rose(done_ff) |->
         (O_MGMT_ADDR == {$past(pins_s[PIN_RXD_LSB +: RXD_W]),
                          $past(pins_s[PIN_COL])}))
      else $error("address strap not captured");

   crs_mii_a: assert property (
      @(posedge I_LINK_CLK) disable iff (I_RST)
      (!rmii_s && I_RX_ACTIVE) |=> O_CRS)
      else $error("carrier sense missing on busy medium");

   crs_rmii_a: assert property (
      @(posedge I_LINK_CLK) disable iff (I_RST)
      (rmii_s && (I_RX_ACTIVE || I_SYM_VALID)) |=> O_CRS)
      else $error("combined carrier not shown in rmii");

   col_fdx_a: assert property (
      @(posedge I_LINK_CLK) disable iff (I_RST)
      (!rmii_s && fdx_s) |=> !O_COL)
      else $error("collision in full duplex");

   col_hdx_a: assert property (
      @(posedge I_LINK_CLK) disable iff (I_RST)
      (!rmii_s && !fdx_s) |=>
         (O_COL == ($past(I_TX_ACTIVE) && $past(I_RX_ACTIVE))))
      else $error("half duplex collision wrong");

   col_rmii_a: assert property (
      @(posedge I_LINK_CLK) disable iff (I_RST)
      rmii_s |=> !O_COL)
      else $error("collision driven in rmii");

   strap_hold_a: assert property (
      @(posedge I_CORE_CLK) disable iff (I_RST)
      !done_ff |-> ##1 !O_PINS_OE)
      else $error("pins driven before straps latched");

   swap_gate_a: assert property (
      @(posedge I_CORE_CLK) disable iff (I_RST)
      !xover_en_ff |=> !O_PAIRS_SWAPPED)
      else $error("pairs swapped with crossover off");

   line_speed_a: assert property (
      @(posedge I_CORE_CLK) disable iff (I_RST)
      I_SPEED_100 |=> O_LINE_100)
      else $error("line pairs not set for 100 mb/s");

   rxclk_rate_a: assert property (
      @(posedge I_CORE_CLK) disable iff (I_RST)
      (rmii_ff || !I_SPEED_100) |=> !O_RXCLK_25M)
      else $error("fast receive clock chosen at 10 mb/s or rmii");
endmodule : mrx_rx_port

// *** bench/mrx_mac_model.sv ***
// mac-side receiver model that counts delivered data cycles
`timescale 1ns/1ps
module mrx_mac_model (
   input  wire logic i_clk,
   input  wire logic i_rmii,
   input  wire logic i_dv,
   input  wire logic i_col,
   output int        o_units,
   output int        o_bad
);
   int units_cnt = 0;
   int bad_cnt   = 0;

   // takes a unit per dv cycle, sampled away from the launching edge;
   // rx error is left unwired on purpose, the data is already corrupted
   always @(negedge i_clk) begin
      if (i_dv === 1'b1) units_cnt <= units_cnt + 1;
      if (i_rmii === 1'b1 && i_col === 1'b1) begin
         bad_cnt <= bad_cnt + 1;
      end
   end

   assign o_units = units_cnt;
   assign o_bad   = bad_cnt;
endmodule : mrx_mac_model

// *** bench/mrx_rx_port_test.sv ***
// self-checking bench for the receive status port
`timescale 1ns/1ps
module mrx_rx_port_test;
   import mrx_pkg::*;
   localparam int SETTLE = 3;
   logic       core_clk = 0, link_clk = 0, rst = 1;
   logic [3:0] s_rxd = 4'h0, sd = 4'h0, rxd;
   logic       s_dv = 0, s_er = 1, s_crs = 1, s_col = 1;
   logic       fdx = 0, spd = 0, swp = 0, sv = 0, se = 0, ra = 0, ta = 0;
   logic       dv, er, crs, col, oe, rmii, cx, ind, done, l100, swd, c25;
   logic [4:0] addr;
   int         miscompares = 0, checks = 0, dv_cnt = 0, units, bad;
   wire [3:0]  p_rxd = oe ? rxd : s_rxd;
   always #50 core_clk = ~core_clk;
   // link clock from the far side, unrelated in phase
   always #16 link_clk = ~link_clk;
   mrx_rx_port #(.SETTLE_CYC(SETTLE)) u_mrx_rx_port (
      .I_CORE_CLK(core_clk), .I_RST(rst), .I_LINK_CLK(link_clk),
      .I_RXD_PIN(p_rxd), .I_RX_DV_PIN(oe ? dv : s_dv),
      .I_RX_ER_PIN(oe ? er : s_er), .I_CRS_PIN(oe ? crs : s_crs),
      .I_COL_PIN(oe ? col : s_col), .I_FULL_DUPLEX(fdx),
      .I_SPEED_100(spd), .I_SWAP_REQ(swp), .I_SYM_VALID(sv),
      .I_SYM_DATA(sd), .I_SYM_ERR(se), .I_RX_ACTIVE(ra),
      .I_TX_ACTIVE(ta), .O_RXD(rxd), .O_RX_DV(dv), .O_RX_ER(er),
      .O_CRS(crs), .O_COL(col), .O_PINS_OE(oe), .O_MGMT_ADDR(addr),
      .O_RMII_MODE(rmii), .O_CROSSOVER_EN(cx), .O_INDICATOR_CFG(ind),
      .O_STRAPS_DONE(done), .O_LINE_100(l100), .O_PAIRS_SWAPPED(swd),
      .O_RXCLK_25M(c25));
   mrx_mac_model u_mrx_mac_model (.i_clk(link_clk), .i_rmii(rmii),
      .i_dv(dv), .i_col(col), .o_units(units), .o_bad(bad));
   // compare and count
   task automatic chk(input logic [15:0] got, exp, input string what);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic finish_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test
   // reset with given straps {col,crs,er,dv,rxd}, then check capture
   task automatic boot(input logic [7:0] st);
      int i;
      @(negedge core_clk);
      {s_col, s_crs, s_er, s_dv, s_rxd} = st;
      rst = 1;
      repeat (6) @(negedge core_clk);
      rst = 0;
      for (i = 0; i < 20 && done !== 1'b1; i++) @(negedge core_clk);
      chk(16'(i), 16'(SETTLE + 2), "capture edge");
      chk(16'(oe), 16'h0, "pins early");
      chk(16'(addr), 16'({s_rxd, s_col}), "address");
      chk(16'({rmii, cx, ind}), 16'({s_dv, s_er, s_crs}), "straps");
      @(negedge core_clk);
      chk(16'(oe), 16'h1, "pins on");
   endtask : boot
   // random receive traffic against the reference model
   task automatic traffic(input int n, input logic f);
      logic [3:0] ed;
      logic       ev, ee, ec, ecol;
      @(negedge core_clk);
      fdx = f;
      repeat (3) @(negedge core_clk);
      for (int k = 0; k <= n; k++) begin
         @(negedge link_clk);
         if (k > 0) begin
            chk(16'(dv), 16'(ev), "dv");
            chk(16'(er), 16'(ee), "er");
            if (ev) chk(16'(rxd), 16'(ed), "rxd");
            chk(16'(crs), 16'(ec), "crs");
            chk(16'(col), 16'(ecol), "col");
         end
         sv = (k < n) ? 1'($urandom_range(1)) : 1'b0;
         se = sv & ($urandom_range(3) == 0);
         sd = 4'($urandom_range(15));
         // media go idle at the end so no collision outlives the burst
         ra = (k < n) ? 1'($urandom_range(1)) : 1'b0;
         ta = (k < n) ? 1'($urandom_range(1)) : 1'b0;
         dv_cnt += sv;
         ev = sv;
         ee = se;
         ed = s_dv ? {2'b00, sd[1:0]} : sd;
         if (se) ed = s_dv ? (CORRUPT_NIBBLE & 4'h3) : CORRUPT_NIBBLE;
         ec = s_dv ? (ra | sv) : ra;
         ecol = !s_dv & !fdx & ra & ta;
      end
      // let the mac model take the last valid cycle before any reset
      @(negedge link_clk);
   endtask : traffic
   // core config: speed, swap request, receive clock select
   task automatic cfg(input int n);
      for (int k = 0; k < n; k++) begin
         spd = 1'($urandom_range(1));
         swp = 1'($urandom_range(1));
         @(negedge core_clk);
         chk(16'(l100), 16'(spd), "speed");
         chk(16'(swd), 16'(s_er & swp), "swap");
         chk(16'(c25), 16'(!s_dv & spd), "rx clock");
      end
   endtask : cfg
   // main sequence: default straps, random mii straps, rmii
   initial begin
      void'($urandom(32'hedcb_741c));
      boot(8'hE0);
      cfg(16);
      traffic(200, 1'b0);
      traffic(200, 1'b1);
      boot({3'($urandom_range(7)), 1'b0, 4'($urandom_range(15))});
      cfg(16);
      traffic(200, 1'b0);
      boot({1'b1, 1'b1, 1'b0, 1'b1, 4'($urandom_range(15))});
      cfg(16);
      traffic(200, 1'b0);
      repeat (4) @(negedge link_clk);
      chk(16'(units), 16'(dv_cnt), "mac units");
      chk(16'(bad), 16'h0, "mac collisions");
      finish_test;
   end
   // watchdog: the run needs about 40 us, so 1 ms means a hang
   initial begin
      #1_000_000;
      miscompares++;
      finish_test;
   end
endmodule : mrx_rx_port_test
